// ---- rtl/fps_defines.svh ----
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_CLK_MHZ            10
`define FPS_SECTOR_ERASE_MAX_S 8
`define FPS_CHIP_ERASE_MAX_S   24
`define FPS_PROGRAM_MAX_US     210
`define FPS_LOAD_WINDOW_US     100
`define FPS_PROTECT_PULSE_US   10
`define FPS_UNPROTECT_PULSE_MS 12
`define FPS_OE_LEAD_US         4
`define FPS_SECTOR_ERASE_CYC   (`FPS_SECTOR_ERASE_MAX_S * 1000000 * `FPS_CLK_MHZ)
`define FPS_CHIP_ERASE_CYC     (`FPS_CHIP_ERASE_MAX_S * 1000000 * `FPS_CLK_MHZ)
`define FPS_PROGRAM_CYC        (`FPS_PROGRAM_MAX_US * `FPS_CLK_MHZ)
`define FPS_LOAD_WINDOW_CYC    (`FPS_LOAD_WINDOW_US * `FPS_CLK_MHZ)
`define FPS_PROTECT_CYC        (`FPS_PROTECT_PULSE_US * `FPS_CLK_MHZ)
`define FPS_UNPROTECT_CYC      (`FPS_UNPROTECT_PULSE_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OE_LEAD_CYC        (`FPS_OE_LEAD_US * `FPS_CLK_MHZ)
`define FPS_STATUS_POL_BIT     7
`define FPS_STATUS_TOG_BIT     6
`define FPS_SECTOR_LO_BIT      13
`define FPS_SECTOR_HI_BIT      16
`define FPS_CMD_WIDTH_CYC      2

`endif

// ---- rtl/fps_flash_host.sv ----
`timescale 1ns/1ps
`include "fps_defines.svh"
// Behaviour
// - the host ends a program by polling the polarity and toggle status bits.
// - the host ends an erase by polling the polarity and toggle status bits.
// - the sector load window lasts at least 100 us before the erase starts.
// - a protect pulse holds the write strobe low for at least 10 us.
// - an unprotect pulse holds the write strobe low for at least 12 ms.
// - for a protect or unprotect pulse, the output strobe is asserted at least 4 us before the write strobe.
module fps_flash_host #(
    parameter int unsigned SECT_ERASE_CYC = `FPS_SECTOR_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYC = `FPS_CHIP_ERASE_CYC,
    parameter int unsigned UNPROT_CYC     = `FPS_UNPROTECT_CYC
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // user request
    input  wire logic        req_valid_in,
    input  wire logic [2:0]  req_op_in,
    input  wire logic [16:0] req_addr_in,
    input  wire logic [7:0]  req_data_in,
    output logic             req_ready_out,
    output logic             done_out,
    output logic             timeout_out,
    output logic [7:0]       status_out,
    // flash pins
    output logic [16:0]      fl_addr_out,
    output logic [7:0]       fl_data_out,
    output logic             fl_data_oe_out,
    input  wire logic [7:0]  fl_data_in,
    output logic             fl_ce_n_out,
    output logic             fl_oe_n_out,
    output logic             fl_we_n_out
);
    typedef enum logic [2:0] {
        FPS_IDLE   = 3'h0,
        FPS_WRITE  = 3'h1,
        FPS_LOAD   = 3'h2,
        FPS_READ   = 3'h3,
        FPS_CHECK  = 3'h4,
        FPS_LEAD   = 3'h5,
        FPS_PULSE  = 3'h6,
        FPS_FINISH = 3'h7
    } fps_state_e;

    // limits below a few cycles would let a poll or pulse end before it starts
    if (SECT_ERASE_CYC < 16) begin : g_sect_limit_check
        $error("fps_flash_host: sector erase limit too small");
    end
    if (CHIP_ERASE_CYC < 16) begin : g_chip_limit_check
        $error("fps_flash_host: chip erase limit too small");
    end
    if (UNPROT_CYC < 16) begin : g_unprot_limit_check
        $error("fps_flash_host: unprotect pulse too short");
    end

    fps_state_e      state_reg;
    fps_pkg::fps_op_e op_reg;
    logic [31:0]     timer_reg;
    logic [31:0]     wait_reg;
    logic [7:0]      data_reg;
    logic [7:0]      sync1_reg;
    logic [7:0]      sync2_reg;
    logic            take;
    logic            pulse_op;
    fps_poll_if      poll ();

    fps_poll_check u_check (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .poll       (poll)
    );

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= fl_data_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign poll.start       = (state_reg == FPS_IDLE);
    assign poll.erase       = (op_reg != fps_pkg::FPS_OP_PROGRAM);
    assign poll.expect_data = data_reg;
    assign poll.read_data   = sync2_reg;
    assign poll.sample      = (state_reg == FPS_CHECK);

    assign take     = (state_reg == FPS_IDLE) && req_valid_in;
    assign pulse_op = (req_op_in == fps_pkg::FPS_OP_PROTECT) ||
                      (req_op_in == fps_pkg::FPS_OP_UNPROTECT);

    // request capture: operation, expected byte and the limit of its poll or pulse
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            op_reg   <= fps_pkg::FPS_OP_PROGRAM;
            data_reg <= 8'h00;
            wait_reg <= 32'h0000_0000;
        end else if (take) begin
            op_reg   <= fps_pkg::fps_op_e'(req_op_in);
            data_reg <= req_data_in;
            unique case (req_op_in)
                fps_pkg::FPS_OP_SECT_ERS:  wait_reg <= SECT_ERASE_CYC;
                fps_pkg::FPS_OP_CHIP_ERS:  wait_reg <= CHIP_ERASE_CYC;
                fps_pkg::FPS_OP_UNPROTECT: wait_reg <= UNPROT_CYC;
                fps_pkg::FPS_OP_PROTECT:   wait_reg <= `FPS_PROTECT_CYC;
                default:                   wait_reg <= `FPS_PROGRAM_CYC;
            endcase
        end
    end

    // write data drive, held one cycle past the rising write strobe so the
    // byte still stands on the bus when the flash latches it
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fl_data_out    <= 8'h00;
            fl_data_oe_out <= 1'b0;
        end else if (take && !pulse_op) begin
            fl_data_out    <= req_data_in;
            fl_data_oe_out <= 1'b1;
        end else if (state_reg == FPS_LOAD || state_reg == FPS_READ) begin
            fl_data_oe_out <= 1'b0;
        end
    end

    // main sequence
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg      <= FPS_IDLE;
            timer_reg      <= 32'h0000_0000;
            req_ready_out  <= 1'b1;
            done_out       <= 1'b0;
            timeout_out    <= 1'b0;
            status_out     <= 8'h00;
            fl_addr_out    <= 17'h0_0000;
            fl_ce_n_out    <= 1'b1;
            fl_oe_n_out    <= 1'b1;
            fl_we_n_out    <= 1'b1;
        end else begin
            done_out    <= 1'b0;
            timeout_out <= 1'b0;
            timer_reg   <= timer_reg + 32'h0000_0001;
            unique case (state_reg)
                FPS_IDLE: begin
                    if (req_valid_in) begin
                        fl_addr_out    <= req_addr_in;
                        req_ready_out  <= 1'b0;
                        timer_reg      <= 32'h0000_0000;
                        fl_ce_n_out    <= 1'b0;
                        if (pulse_op) begin
                            fl_oe_n_out <= 1'b0;
                            state_reg   <= FPS_LEAD;
                        end else begin
                            fl_we_n_out    <= 1'b0;
                            state_reg      <= FPS_WRITE;
                        end
                    end
                end
                FPS_WRITE: begin
                    if (timer_reg >= `FPS_CMD_WIDTH_CYC - 1) begin
                        fl_we_n_out    <= 1'b1;
                        timer_reg      <= 32'h0000_0000;
                        state_reg <= (op_reg == fps_pkg::FPS_OP_SECT_ERS) ? FPS_LOAD : FPS_READ;
                    end
                end
                FPS_LOAD: begin
                    if (timer_reg >= `FPS_LOAD_WINDOW_CYC) begin
                        timer_reg <= 32'h0000_0000;
                        state_reg <= FPS_READ;
                    end
                end
                FPS_READ: begin
                    fl_oe_n_out <= 1'b0;
                    if (timer_reg[1:0] == 2'h3) begin
                        state_reg <= FPS_CHECK;
                    end
                end
                FPS_CHECK: begin
                    fl_oe_n_out <= 1'b1;
                    status_out  <= sync2_reg;
                    if (poll.verdict == fps_pkg::FPS_POLL_OK) begin
                        state_reg <= FPS_FINISH;
                    end else if (timer_reg >= wait_reg) begin
                        timeout_out <= 1'b1;
                        state_reg   <= FPS_FINISH;
                    end else begin
                        state_reg <= FPS_READ;
                    end
                end
                FPS_LEAD: begin
                    if (timer_reg >= `FPS_OE_LEAD_CYC) begin
                        fl_we_n_out <= 1'b0;
                        timer_reg   <= 32'h0000_0000;
                        state_reg   <= FPS_PULSE;
                    end
                end
                FPS_PULSE: begin
                    if (timer_reg >= wait_reg) begin
                        fl_we_n_out <= 1'b1;
                        state_reg   <= FPS_FINISH;
                    end
                end
                FPS_FINISH: begin
                    fl_oe_n_out   <= 1'b1;
                    fl_ce_n_out   <= 1'b1;
                    done_out      <= 1'b1;
                    req_ready_out <= 1'b1;
                    state_reg     <= FPS_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- rtl/fps_pkg.sv ----
package fps_pkg;
    typedef enum logic [2:0] {
        FPS_OP_PROGRAM   = 3'h0,
        FPS_OP_CHIP_ERS  = 3'h1,
        FPS_OP_SECT_ERS  = 3'h2,
        FPS_OP_PROTECT   = 3'h3,
        FPS_OP_UNPROTECT = 3'h4
    } fps_op_e;
    typedef enum logic [1:0] {
        FPS_POLL_OK      = 2'h0,
        FPS_POLL_BUSY    = 2'h1,
        FPS_POLL_TIMEOUT = 2'h2
    } fps_poll_e;
endpackage

// ---- rtl/fps_poll_check.sv ----
`timescale 1ns/1ps
`include "fps_defines.svh"
module fps_poll_check (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // status reads
    fps_poll_if.chk   poll
);
    logic       prev_tog_reg;
    logic       have_prev_reg;

    // remembers the previous toggle bit between two reads
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_tog_reg  <= 1'b0;
            have_prev_reg <= 1'b0;
        end else if (poll.start) begin
            have_prev_reg <= 1'b0;
        end else if (poll.sample) begin
            prev_tog_reg  <= poll.read_data[`FPS_STATUS_TOG_BIT];
            have_prev_reg <= 1'b1;
        end
    end

    // done when polarity bit shows the true value and the toggle bit stops toggling
    always_comb begin
        logic pol_done;
        logic tog_done;
        pol_done = poll.erase ? poll.read_data[`FPS_STATUS_POL_BIT]
                 : (poll.read_data[`FPS_STATUS_POL_BIT] ==
                    poll.expect_data[`FPS_STATUS_POL_BIT]);
        tog_done = have_prev_reg &&
                   (prev_tog_reg == poll.read_data[`FPS_STATUS_TOG_BIT]);
        poll.verdict = (pol_done && tog_done) ? fps_pkg::FPS_POLL_OK
                                              : fps_pkg::FPS_POLL_BUSY;
    end
endmodule

// ---- rtl/fps_poll_if.sv ----
`timescale 1ns/1ps
interface fps_poll_if;
    logic       start;
    logic       erase;
    logic [7:0] expect_data;
    logic [7:0] read_data;
    logic       sample;
    fps_pkg::fps_poll_e verdict;
    modport ctrl (output start, output erase, output expect_data, output read_data,
                  output sample, input verdict);
    modport chk  (input start, input erase, input expect_data, input read_data,
                  input sample, output verdict);
endinterface

// ---- test/fps_flash_host_props.sv ----
`timescale 1ns/1ps
module fps_flash_host_props #(
    parameter int unsigned SECT_ERASE_CYC = 200,
    parameter int unsigned CHIP_ERASE_CYC = 200,
    parameter int unsigned UNPROT_CYC     = 200
) (
    // user side
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       req_valid_in,
    input  wire logic [2:0] req_op_in,
    input  wire logic [7:0] req_data_in,
    input  wire logic       req_ready_out,
    input  wire logic       timeout_out,
    // flash pins
    input  wire logic [7:0] fl_data_out,
    input  wire logic       fl_data_oe_out,
    input  wire logic       fl_ce_n_out,
    input  wire logic       fl_oe_n_out,
    input  wire logic       fl_we_n_out
);
    logic [2:0]  op_reg;
    logic [31:0] cnt_reg;
    logic [31:0] low_reg;
    // cycles since the request was taken, and write strobe low time
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            op_reg  <= 3'h0;
            cnt_reg <= 32'h0;
        end else if (req_valid_in && req_ready_out) begin
            op_reg  <= req_op_in;
            cnt_reg <= 32'h0;
        end else
            cnt_reg <= cnt_reg + 32'h1;
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            low_reg <= 32'h0;
        else
            low_reg <= fl_we_n_out ? 32'h0 : low_reg + 32'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_take; req_valid_in && req_ready_out; endsequence
    sequence s_write; !fl_ce_n_out && !fl_we_n_out && fl_data_oe_out; endsequence
    property p_write;
        s_take ##0 (req_op_in == fps_pkg::FPS_OP_PROGRAM)
            |=> s_write ##0 (fl_data_out == $past(req_data_in));
    endproperty
    property p_we_width;
        $fell(fl_we_n_out) && fl_oe_n_out |-> !fl_we_n_out [*2] ##1 fl_we_n_out;
    endproperty
    property p_lead; $fell(fl_we_n_out) && !fl_oe_n_out |-> !$past(fl_oe_n_out, 40); endproperty
    property p_prot_width;
        $rose(fl_we_n_out) && op_reg == fps_pkg::FPS_OP_PROTECT |-> low_reg >= 100;
    endproperty
    property p_unprot_width;
        $rose(fl_we_n_out) && op_reg == fps_pkg::FPS_OP_UNPROTECT |-> low_reg >= UNPROT_CYC;
    endproperty
    property p_load;
        $fell(fl_oe_n_out) && op_reg == fps_pkg::FPS_OP_SECT_ERS |-> cnt_reg >= 1000;
    endproperty
    property p_prog_to;
        timeout_out && op_reg == fps_pkg::FPS_OP_PROGRAM |-> cnt_reg >= 2100;
    endproperty
    property p_chip_to;
        timeout_out && op_reg == fps_pkg::FPS_OP_CHIP_ERS |-> cnt_reg >= CHIP_ERASE_CYC;
    endproperty
    a_write: assert property (p_write) else $error("bad data write");
    a_we_width: assert property (p_we_width) else $error("bad write width");
    a_lead: assert property (p_lead) else $error("output strobe lead short");
    a_prot_width: assert property (p_prot_width) else $error("protect short");
    a_unprot_width: assert property (p_unprot_width) else $error("unprotect short");
    a_load: assert property (p_load) else $error("poll inside load window");
    a_prog_to: assert property (p_prog_to) else $error("early program timeout");
    a_chip_to: assert property (p_chip_to) else $error("early erase timeout");
endmodule
bind fps_flash_host fps_flash_host_props #(.SECT_ERASE_CYC(SECT_ERASE_CYC),
    .CHIP_ERASE_CYC(CHIP_ERASE_CYC), .UNPROT_CYC(UNPROT_CYC)) u_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .timeout_out(timeout_out), .fl_data_out(fl_data_out), .fl_data_oe_out(fl_data_oe_out),
    .fl_ce_n_out(fl_ce_n_out), .fl_oe_n_out(fl_oe_n_out), .fl_we_n_out(fl_we_n_out));

// ---- test/fps_flash_host_tb.sv ----
`timescale 1ns/1ps
module fps_flash_host_tb;
    logic        clk_in       = 1'b0;
    logic        sys_rst_in   = 1'b1;
    logic        req_valid_in = 1'b0;
    logic [2:0]  req_op_in    = 3'h0;
    logic [16:0] req_addr_in  = 17'h00000;
    logic [7:0]  req_data_in  = 8'h00;
    logic        erase        = 1'b0;
    logic [31:0] busy_ns      = 32'h0;
    logic        ready, done, tmo, data_oe, ce_n, oe_n, we_n;
    logic [7:0]  status, hdata, mdata;
    logic [16:0] addr;
    logic [3:0]  sector;
    wire  [7:0]  bus = data_oe ? hdata : mdata;
    int          bad_count = 0;
    int          check_count = 0;
    fps_flash_host #(.SECT_ERASE_CYC(2000), .CHIP_ERASE_CYC(200), .UNPROT_CYC(300)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
        .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
        .req_ready_out(ready), .done_out(done), .timeout_out(tmo), .status_out(status),
        .fl_addr_out(addr), .fl_data_out(hdata), .fl_data_oe_out(data_oe), .fl_data_in(bus),
        .fl_ce_n_out(ce_n), .fl_oe_n_out(oe_n), .fl_we_n_out(we_n));
    fps_flash_model model (.addr_in(addr), .data_in(bus), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .erase_in(erase), .busy_ns_in(busy_ns), .data_out(mdata),
        .sector_out(sector));
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d,
                          input logic er, input int ns, output logic [7:0] st, output logic to);
        int n;
        n = 0;
        erase = er;
        busy_ns = ns;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_op_in <= op;
        req_addr_in <= a;
        req_data_in <= d;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        to = 1'b0;
        // the timeout pulse comes one cycle ahead of the done pulse
        do begin
            @(negedge clk_in);
            n++;
            if (tmo === 1'b1)
                to = 1'b1;
        end while (done !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            bad_count++;
            end_of_test();
        end else begin
            st = status;
        end
    endtask
    task automatic t_program();
        logic [7:0] st;
        logic       to;
        run_op(3'h0, 17'h00123, 8'hA5, 1'b0, 20000, st, to);
        check8("program status", 8'hA5, st);
        check8("program timeout", 8'h00, {7'h0, to});
        run_op(3'h0, 17'h00124, 8'h5A, 1'b0, 20000, st, to);
        check8("program readback", 8'h5A, st);
        run_op(3'h0, 17'h00125, 8'h3C, 1'b0, 250000, st, to);
        check8("program limit", 8'h01, {7'h0, to});
        #250000;
    endtask
    task automatic t_erase();
        logic [7:0] st;
        logic       to;
        run_op(3'h2, 17'h1A5A5, 8'h30, 1'b1, 150000, st, to);
        check8("sector status", 8'hFF, st);
        check8("sector timeout", 8'h00, {7'h0, to});
        check8("sector select", 8'h0D, {4'h0, sector});
        run_op(3'h1, 17'h00000, 8'h10, 1'b1, 10000, st, to);
        check8("chip status", 8'hFF, st);
        run_op(3'h1, 17'h00000, 8'h10, 1'b1, 100000, st, to);
        check8("chip limit", 8'h01, {7'h0, to});
        #100000;
    endtask
    task automatic t_protect();
        logic [7:0] st;
        logic       to;
        run_op(3'h3, 17'h00000, 8'h00, 1'b0, 0, st, to);
        check8("protect timeout", 8'h00, {7'h0, to});
        run_op(3'h4, 17'h00000, 8'h00, 1'b0, 0, st, to);
        check8("unprotect timeout", 8'h00, {7'h0, to});
    endtask
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_program();
        t_erase();
        t_protect();
        end_of_test();
    end
endmodule

// ---- test/fps_flash_model.sv ----
`timescale 1ns/1ps
module fps_flash_model (
    // host side
    input  wire logic [16:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    // test control
    input  wire logic        erase_in,
    input  wire logic [31:0] busy_ns_in,
    output logic [7:0]       data_out,
    output logic [3:0]       sector_out
);
    logic [7:0] word_reg = 8'hFF;
    logic [7:0] last_reg = 8'h00;
    logic       busy_reg = 1'b0;
    logic       tog_reg  = 1'b0;
    logic [7:0] drive_val;
    // one write runs the whole operation with internal verify
    always @(posedge we_n_in) begin
        if (!ce_n_in && oe_n_in) begin
            word_reg = erase_in ? 8'hFF : data_in;
            sector_out = addr_in[16:13];
            busy_reg = 1'b1;
            busy_reg <= #(busy_ns_in) 1'b0;
        end
    end
    always @(negedge oe_n_in) if (busy_reg) tog_reg = ~tog_reg;
    // value the array drives while selected and read
    always @* begin
        if (busy_reg)
            drive_val = {erase_in ? 1'b0 : ~word_reg[7],
                         tog_reg, word_reg[5:0]};
        else
            drive_val = word_reg;
    end
    // taken from the driven value, not from the bus, so the release cannot race it
    always @(posedge oe_n_in or posedge ce_n_in) last_reg = drive_val;
    // released bus shows the inverse of the last value
    always @* data_out = (ce_n_in || oe_n_in) ? ~last_reg : drive_val;
endmodule
